/* File: inc/rtc_regs.svh */
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH

// register byte offsets
`define RTC_OFF_CFG  8'h00
`define RTC_OFF_HIGH 8'h04
`define RTC_OFF_LOW  8'h08

// config field positions
`define RTC_BIT_EN   15
`define RTC_BIT_NC   14
`define RTC_BIT_WREN 13
`define RTC_BIT_SYNC 12
`define RTC_BIT_HALF 11
`define RTC_BIT_OE   10
`define RTC_PTR_HI   9
`define RTC_PTR_LO   8

// reset values
`define RTC_RST_CFG   16'h0000
`define RTC_RST_DAY   8'h01
`define RTC_RST_MONTH 8'h01

// axi responses
`define RTC_RESP_OKAY   2'b00
`define RTC_RESP_SLVERR 2'b10

// timing
`define RTC_CLK_NS        8
`define RTC_SECOND_NS     1000000000
`define RTC_SYNC_LEAD_NS  256
`define RTC_SECOND_CYCLES (`RTC_SECOND_NS / `RTC_CLK_NS)
`define RTC_SYNC_CYCLES   ((`RTC_SYNC_LEAD_NS + `RTC_CLK_NS - 1) / `RTC_CLK_NS)
`define RTC_CNT_W         27

`endif

/* File: inc/rtc_pkg.sv */
`include "rtc_regs.svh"

package rtc_pkg;

  typedef enum logic [1:0] {
    PAIR_MIN_SEC   = 2'b00,
    PAIR_WDAY_HOUR = 2'b01,
    PAIR_MONTH_DAY = 2'b10,
    PAIR_YEAR      = 2'b11
  } pair_sel_t;

  typedef enum logic [1:0] {
    SEL_CFG  = 2'b00,
    SEL_HIGH = 2'b01,
    SEL_LOW  = 2'b10,
    SEL_NONE = 2'b11
  } reg_sel_t;

  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] day;
    logic [7:0] wday;
    logic [7:0] hour;
    logic [7:0] minute;
    logic [7:0] second;
  } cal_time_t;

  typedef struct packed {
    logic [`RTC_CNT_W-1:0] count;
    logic                  tick;
    logic                  half;
    logic                  sync;
  } timer_state_t;

  typedef struct packed {
    logic       en;
    logic       wren;
    logic       oe;
    logic [1:0] ptr;
    logic [7:0] cal;
    cal_time_t  tm;
    logic       aw_held;
    logic [7:0] awaddr;
    logic       w_held;
    logic [15:0] wdata;
    logic [1:0] wstrb;
    logic       awready;
    logic       wready;
    logic       bvalid;
    logic [1:0] bresp;
    logic       arready;
    logic       rvalid;
    logic [1:0] rresp;
    logic [15:0] rdata;
    logic       clk_out;
    logic       clk_oe;
  } ctl_state_t;

endpackage

/* File: logic/rtc_second_timer.sv */
`timescale 1ns/1ps
`include "rtc_regs.svh"

module rtc_second_timer #(
  parameter int unsigned SECOND_CYCLES = `RTC_SECOND_CYCLES
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic run,
  input  wire logic restart,
  output logic      tick,
  output logic      half_second,
  output logic      sync_window
);

  localparam int unsigned W = `RTC_CNT_W;
  localparam logic [W-1:0] LAST = W'(SECOND_CYCLES - 1);
  localparam logic [W-1:0] HALF = W'(SECOND_CYCLES / 2);
  localparam logic [W-1:0] SYNC_AT = W'(SECOND_CYCLES - `RTC_SYNC_CYCLES);

  rtc_pkg::timer_state_t s_q;
  rtc_pkg::timer_state_t s_d;

  // prescaler: count within the second, tick at rollover
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (restart) begin
      s_d.count = '0;
    end else if (run) begin
      if (s_q.count == LAST) begin
        s_d.count = '0;
        s_d.tick = 1'b1;
      end else begin
        s_d.count = s_q.count + W'(1);
      end
    end
    s_d.half = (s_d.count >= HALF);
    // flag covers the lead cycles and the ripple cycle itself
    s_d.sync = run && !restart && ((s_d.count >= SYNC_AT) || s_d.tick);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;
  assign half_second = s_q.half;
  assign sync_window = s_q.sync;

endmodule

/* File: logic/rtc_cfg_top.sv */
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "rtc_regs.svh"

// Functional notes
// - The clock counts time only while the module enable bit 15 is 1.
// - Writes to the high and low value windows take effect only while bit 13 is 1.
// - The read sync flag bit 12 is 1 while a rollover ripple may change the values.
// - The read sync flag is 0 only when values can be read without ripple risk.
// - Bit 11 reads 1 in the second half of each second and 0 in the first.
// - The clock output pin is driven only while the output enable bit 10 is 1.
// - The pointer picks min/sec, weekday/hour, month/day or reserved/year.
// - Each access to the high window decrements the pointer, stopping at zero.
// - Bit 14 of the config register reads as zero.
// - Only the power-on reset clears the config register; warm reset keeps it.
// - A write to the enable bit is taken only while the write enable bit is 1.
// - The half-second bit is read only and clears on a min/sec low write.

module rtc_cfg_top #(
  parameter int unsigned SECOND_CYCLES = `RTC_SECOND_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        warm_reset,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             clock_out,
  output logic             clock_out_en,
  output logic [7:0]       cal_byte,
  output logic             clock_module_enable
);

  rtc_pkg::ctl_state_t q;
  rtc_pkg::ctl_state_t d;
  rtc_pkg::cal_time_t  tm;
  rtc_pkg::reg_sel_t   wr_sel;
  rtc_pkg::reg_sel_t   rd_sel;
  logic                wr_fire;
  logic                ar_fire;
  logic                restart;
  logic                carry;
  logic [7:0]          mdays;
  logic [1:0]          ptr;
  logic                tick;
  logic                half;
  logic                sync;
  logic [15:0]         pw;

  // register offset to register select
  function automatic rtc_pkg::reg_sel_t decode(input logic [7:0] a);
    case (a)
      `RTC_OFF_CFG:  return rtc_pkg::SEL_CFG;
      `RTC_OFF_HIGH: return rtc_pkg::SEL_HIGH;
      `RTC_OFF_LOW:  return rtc_pkg::SEL_LOW;
      default:       return rtc_pkg::SEL_NONE;
    endcase
  endfunction

  // bcd increment with wrap from hi back to lo
  function automatic logic [7:0] bcd_next(input logic [7:0] v,
                                          input logic [7:0] lo,
                                          input logic [7:0] hi);
    if (v >= hi) begin
      return lo;
    end
    if (v[3:0] >= 4'h9) begin
      return {v[7:4] + 4'h1, 4'h0};
    end
    return {v[7:4], v[3:0] + 4'h1};
  endfunction

  // last day of the month, leap year every fourth year
  function automatic logic [7:0] month_days(input logic [7:0] m,
                                            input logic [7:0] y);
    logic [1:0] ymod;
    ymod = 2'(y[3:0]) + {y[4], 1'b0};
    case (m)
      8'h02:                      return (ymod == 2'h0) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
      default:                    return 8'h31;
    endcase
  endfunction

  // value pair seen through the window
  function automatic logic [15:0] pair_word(input rtc_pkg::cal_time_t t,
                                            input logic [1:0] p);
    unique case (rtc_pkg::pair_sel_t'(p))
      rtc_pkg::PAIR_MIN_SEC:   return {t.minute, t.second};
      rtc_pkg::PAIR_WDAY_HOUR: return {t.wday, t.hour};
      rtc_pkg::PAIR_MONTH_DAY: return {t.month, t.day};
      rtc_pkg::PAIR_YEAR:      return {8'h00, t.year};
    endcase
  endfunction

  // one-second prescaler
  rtc_second_timer #(
    .SECOND_CYCLES (SECOND_CYCLES)
  ) u_timer (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .run         (q.en),
    .restart     (restart),
    .tick        (tick),
    .half_second (half),
    .sync_window (sync)
  );

  // next state of the whole block
  always_comb begin
    d = q;
    wr_fire = q.aw_held && q.w_held && !q.bvalid;
    wr_sel = decode(q.awaddr);
    ar_fire = arvalid && q.arready;
    rd_sel = decode(araddr);
    tm = q.tm;
    carry = 1'b0;
    restart = 1'b0;
    mdays = month_days(q.tm.month, q.tm.year);
    ptr = q.ptr;
    pw = pair_word(q.tm, q.ptr);

    // calendar ripple at the end of each second
    if (tick) begin
      carry = (tm.second == 8'h59);
      tm.second = bcd_next(tm.second, 8'h00, 8'h59);
      if (carry) begin
        carry = (tm.minute == 8'h59);
        tm.minute = bcd_next(tm.minute, 8'h00, 8'h59);
        if (carry) begin
          carry = (tm.hour == 8'h23);
          tm.hour = bcd_next(tm.hour, 8'h00, 8'h23);
          if (carry) begin
            tm.wday = bcd_next(tm.wday, 8'h00, 8'h06);
            carry = (tm.day >= mdays);
            tm.day = bcd_next(tm.day, 8'h01, mdays);
            if (carry) begin
              carry = (tm.month == 8'h12);
              tm.month = bcd_next(tm.month, 8'h01, 8'h12);
              if (carry) begin
                tm.year = bcd_next(tm.year, 8'h00, 8'h99);
              end
            end
          end
        end
      end
    end

    // window writes, gated by the write enable
    if (wr_fire && q.wren && q.wstrb[0]) begin
      if (wr_sel == rtc_pkg::SEL_LOW) begin
        unique case (rtc_pkg::pair_sel_t'(q.ptr))
          rtc_pkg::PAIR_MIN_SEC: begin
            tm.second = q.wdata[7:0];
            restart = 1'b1;
          end
          rtc_pkg::PAIR_WDAY_HOUR: tm.hour = q.wdata[7:0];
          rtc_pkg::PAIR_MONTH_DAY: tm.day = q.wdata[7:0];
          rtc_pkg::PAIR_YEAR:      tm.year = q.wdata[7:0];
        endcase
      end else if (wr_sel == rtc_pkg::SEL_HIGH) begin
        unique case (rtc_pkg::pair_sel_t'(q.ptr))
          rtc_pkg::PAIR_MIN_SEC:   tm.minute = q.wdata[7:0];
          rtc_pkg::PAIR_WDAY_HOUR: tm.wday = q.wdata[7:0];
          rtc_pkg::PAIR_MONTH_DAY: tm.month = q.wdata[7:0];
          rtc_pkg::PAIR_YEAR:      ;
        endcase
      end
    end
    d.tm = tm;

    // config writes; status bits are not writable
    if (wr_fire && wr_sel == rtc_pkg::SEL_CFG) begin
      if (q.wstrb[0]) begin
        d.cal = q.wdata[7:0];
      end
      if (q.wstrb[1]) begin
        if (q.wren) begin
          d.en = q.wdata[`RTC_BIT_EN];
        end
        d.wren = q.wdata[`RTC_BIT_WREN];
        d.oe = q.wdata[`RTC_BIT_OE];
        ptr = q.wdata[`RTC_PTR_HI:`RTC_PTR_LO];
      end
    end

    // pointer steps down on each high window access
    if (wr_fire && wr_sel == rtc_pkg::SEL_HIGH && ptr != 2'h0) begin
      ptr = ptr - 2'h1;
    end
    if (ar_fire && rd_sel == rtc_pkg::SEL_HIGH && ptr != 2'h0) begin
      ptr = ptr - 2'h1;
    end
    d.ptr = ptr;

    // write channel: hold address and data, answer when both are in
    if (wr_fire) begin
      d.bvalid = 1'b1;
      d.bresp = (wr_sel == rtc_pkg::SEL_NONE) ? `RTC_RESP_SLVERR : `RTC_RESP_OKAY;
      d.aw_held = 1'b0;
      d.w_held = 1'b0;
    end else if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end
    if (awvalid && q.awready) begin
      d.aw_held = 1'b1;
      d.awaddr = awaddr;
    end
    if (wvalid && q.wready) begin
      d.w_held = 1'b1;
      d.wdata = wdata[15:0];
      d.wstrb = wstrb[1:0];
    end

    // read channel: data registered one cycle after the address
    if (ar_fire) begin
      d.rvalid = 1'b1;
      d.rresp = `RTC_RESP_OKAY;
      unique case (rd_sel)
        rtc_pkg::SEL_CFG:  d.rdata = {q.en, 1'b0, q.wren, sync,
                                      half, q.oe, q.ptr, q.cal};
        rtc_pkg::SEL_HIGH: d.rdata = {8'h00, pw[15:8]};
        rtc_pkg::SEL_LOW:  d.rdata = {8'h00, pw[7:0]};
        rtc_pkg::SEL_NONE: begin
          d.rdata = 16'h0000;
          d.rresp = `RTC_RESP_SLVERR;
        end
      endcase
    end else if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end

    // warm reset drops bus traffic but keeps the register contents
    if (warm_reset) begin
      d.aw_held = 1'b0;
      d.w_held = 1'b0;
      d.bvalid = 1'b0;
      d.rvalid = 1'b0;
    end
    d.awready = !d.aw_held && !d.bvalid;
    d.wready = !d.w_held && !d.bvalid;
    d.arready = !d.rvalid;

    // 1 Hz square wave onto the output pin
    d.clk_oe = q.oe;
    d.clk_out = q.oe && q.en && half;
  end

  // power-on reset is the only one that clears the register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.tm.day <= `RTC_RST_DAY;
      q.tm.month <= `RTC_RST_MONTH;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state flops
  assign awready = q.awready;
  assign wready = q.wready;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign arready = q.arready;
  assign rvalid = q.rvalid;
  assign rresp = q.rresp;
  assign rdata = {16'h0000, q.rdata};
  assign clock_out = q.clk_out;
  assign clock_out_en = q.clk_oe;
  assign cal_byte = q.cal;
  assign clock_module_enable = q.en;

  // checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_cfg_read;
    ar_fire && rd_sel == rtc_pkg::SEL_CFG;
  endsequence

  sequence s_minutes_seconds_value_write;
    wr_fire && q.wren && q.wstrb[0] && wr_sel == rtc_pkg::SEL_LOW && q.ptr == 2'h0;
  endsequence

  property p_ptr_step;
    ar_fire && rd_sel == rtc_pkg::SEL_HIGH && q.ptr != 2'h0 && !wr_fire
      |=> q.ptr == $past(q.ptr) - 2'h1;
  endproperty
  a_ptr_step: assert property (p_ptr_step)
    else $error("pointer did not step down on high window read");

  property p_ptr_floor;
    ar_fire && rd_sel == rtc_pkg::SEL_HIGH && q.ptr == 2'h0 && !wr_fire |=> q.ptr == 2'h0;
  endproperty
  a_ptr_floor: assert property (p_ptr_floor)
    else $error("pointer moved below zero");

  property p_lock;
    wr_fire && !q.wren && wr_sel != rtc_pkg::SEL_CFG && !tick |=> $stable(q.tm);
  endproperty
  a_lock: assert property (p_lock)
    else $error("locked value write changed the time");

  property p_en_lock;
    wr_fire && wr_sel == rtc_pkg::SEL_CFG && !q.wren |=> q.en == $past(q.en);
  endproperty
  a_en_lock: assert property (p_en_lock)
    else $error("enable changed while writes locked");

  property p_bit14;
    s_cfg_read |=> q.rvalid && !rdata[`RTC_BIT_NC] && rdata[`RTC_BIT_SYNC] == $past(sync);
  endproperty
  a_bit14: assert property (p_bit14)
    else $error("config read data wrong in bit 14 or sync");

  property p_half_clear;
    s_minutes_seconds_value_write |=> !half [*2];
  endproperty
  a_half_clear: assert property (p_half_clear)
    else $error("half second not cleared by min/sec write");

  property p_sync_lead;
    tick |-> sync && $past(sync);
  endproperty
  a_sync_lead: assert property (p_sync_lead)
    else $error("rollover without sync flag");

  property p_sync_off;
    !q.en |=> !sync;
  endproperty
  a_sync_off: assert property (p_sync_off)
    else $error("sync flag set while clock stopped");

  property p_run;
    !q.en && !wr_fire |=> $stable(q.tm) && !tick;
  endproperty
  a_run: assert property (p_run)
    else $error("time advanced while disabled");

  property p_half_phase;
    tick |-> !half;
  endproperty
  a_half_phase: assert property (p_half_phase)
    else $error("half second set at start of second");

  property p_clk_out;
    !q.oe |=> !clock_out && !clock_out_en;
  endproperty
  a_clk_out: assert property (p_clk_out)
    else $error("clock output driven while disabled");

  property p_warm;
    warm_reset && !wr_fire && !ar_fire |=> $stable({q.en, q.wren, q.oe, q.ptr, q.cal});
  endproperty
  a_warm: assert property (p_warm)
    else $error("warm reset altered config");

endmodule

/* File: sim/rtc_config_and_value_pointer_tb.sv */
`timescale 1ns/1ps
`include "rtc_regs.svh"

module rtc_config_and_value_pointer_tb;
  localparam int unsigned SEC = 256;

  logic        aclk;
  logic        aresetn;
  logic        warm_reset;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        clock_out;
  logic        clock_out_en;
  logic [7:0]  cal_byte;
  logic        clock_module_enable;
  int          n_mismatch;
  int          samples_checked;
  logic [31:0] d;
  logic [1:0]  r;
  logic [7:0]  hi_v [4];
  logic [7:0]  lo_v [4];

  // shortened second keeps the run brief
  rtc_cfg_top #(.SECOND_CYCLES(SEC)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .warm_reset(warm_reset),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .clock_out(clock_out), .clock_out_en(clock_out_en),
    .cal_byte(cal_byte), .clock_module_enable(clock_module_enable)
  );

  // 125 mhz clock
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // axi write: each channel released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
                    output logic [1:0] resp);
    int n;
    bit got;
    n = 0;
    got = 0;
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= v;
    wstrb   <= s;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!got && n < 500) begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        resp = bresp;
        bready <= 1'b0;
        got = 1;
      end
    end
    if (!got) n_mismatch++;
  endtask

  // axi read: rready held until rvalid is seen
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    int n;
    bit got;
    n = 0;
    got = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!got && n < 500) begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        v = rdata;
        resp = rresp;
        rready <= 1'b0;
        got = 1;
      end
    end
    if (!got) n_mismatch++;
  endtask

  task automatic stop_test;
    $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // hang guard, far beyond the expected run length
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    stop_test;
  end

  // main sequence
  initial begin
    n_mismatch = 0;
    samples_checked = 0;
    aresetn = 1'b0;
    warm_reset = 1'b0;
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
    hi_v = '{8'h34, 8'h03, 8'h12, 8'h00};
    lo_v = '{8'h05, 8'h15, 8'h28, 8'h24};
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`RTC_OFF_CFG, d, r);
    chk(d, 32'h0);
    // enable write ignored while the lock bit was clear
    wr(`RTC_OFF_CFG, 32'h0000_a000, 4'h3, r);
    rd(`RTC_OFF_CFG, d, r);
    chk(d & 32'h0000_e7ff, 32'h0000_2000);
    chk({31'h0, clock_module_enable}, 32'h0);
    // now taken; bit 14 stays clear, status bits 12 and 11 are masked out
    wr(`RTC_OFF_CFG, 32'h0000_fc5a, 4'h3, r);
    rd(`RTC_OFF_CFG, d, r);
    chk(d & 32'h0000_e7ff, 32'h0000_a45a);
    chk({31'h0, clock_module_enable}, 32'h1);
    chk({31'h0, clock_out_en}, 32'h1);
    chk({24'h0, cal_byte}, 32'h5a);
    // fill all pairs from pointer 3 down, clock stopped
    wr(`RTC_OFF_CFG, 32'h0000_2700, 4'h3, r);
    for (int p = 3; p >= 0; p--) begin
      wr(`RTC_OFF_LOW, {24'h0, lo_v[p]}, 4'h1, r);
      wr(`RTC_OFF_HIGH, {24'h0, hi_v[p]}, 4'h1, r);
    end
    wr(`RTC_OFF_CFG, 32'h0000_2700, 4'h3, r);
    for (int p = 3; p >= 0; p--) begin
      rd(`RTC_OFF_LOW, d, r);
      chk(d, {24'h0, lo_v[p]});
      rd(`RTC_OFF_HIGH, d, r);
      chk(d, (p == 3) ? 32'h0 : {24'h0, hi_v[p]});
      rd(`RTC_OFF_CFG, d, r);
      chk(d & 32'h0000_0300, 32'((p > 0 ? p - 1 : 0) << 8));
    end
    rd(`RTC_OFF_HIGH, d, r);
    chk(d, 32'h34);
    // lock the windows and stop the clock
    wr(`RTC_OFF_CFG, 32'h0000_0000, 4'h3, r);
    @(negedge aclk);
    chk({31'h0, clock_out_en}, 32'h0);
    chk({31'h0, clock_module_enable}, 32'h0);
    wr(`RTC_OFF_LOW, 32'h59, 4'h1, r);
    chk({30'h0, r}, {30'h0, `RTC_RESP_OKAY});
    wr(`RTC_OFF_HIGH, 32'h11, 4'h1, r);
    rd(`RTC_OFF_HIGH, d, r);
    chk(d, 32'h34);
    repeat (300) @(posedge aclk);
    rd(`RTC_OFF_LOW, d, r);
    chk(d, 32'h05);
    // run the clock from a fresh second
    wr(`RTC_OFF_CFG, 32'h0000_2000, 4'h3, r);
    wr(`RTC_OFF_CFG, 32'h0000_a400, 4'h3, r);
    wr(`RTC_OFF_LOW, 32'h05, 4'h1, r);
    rd(`RTC_OFF_CFG, d, r);
    chk(d & 32'h0000_1800, 32'h0);
    repeat (225) @(posedge aclk);
    rd(`RTC_OFF_CFG, d, r);
    chk(d & 32'h0000_1800, 32'h0000_1800);
    chk({31'h0, clock_out}, 32'h1);
    rd(`RTC_OFF_LOW, d, r);
    chk(d, 32'h05);
    // sync is set here: a second read must match the first
    rd(`RTC_OFF_LOW, d, r);
    chk(d, 32'h05);
    wr(`RTC_OFF_LOW, 32'h07, 4'h1, r);
    rd(`RTC_OFF_CFG, d, r);
    chk(d & 32'h0000_0800, 32'h0);
    repeat (290) @(posedge aclk);
    rd(`RTC_OFF_CFG, d, r);
    chk(d & 32'h0000_1800, 32'h0);
    rd(`RTC_OFF_LOW, d, r);
    chk(d, 32'h08);
    // unmapped offset
    rd(8'h0c, d, r);
    chk({30'h0, r}, {30'h0, `RTC_RESP_SLVERR});
    chk(d, 32'h0);
    wr(8'h0c, 32'hffff, 4'hf, r);
    chk({30'h0, r}, {30'h0, `RTC_RESP_SLVERR});
    // warm reset keeps config, power-on reset clears it
    @(posedge aclk);
    warm_reset <= 1'b1;
    @(posedge aclk);
    warm_reset <= 1'b0;
    rd(`RTC_OFF_CFG, d, r);
    chk(d & 32'h0000_e7ff, 32'h0000_a400);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`RTC_OFF_CFG, d, r);
    chk(d, 32'h0);
    stop_test;
  end
endmodule
